// ==== tb/wsd_core_tb_top.sv ====
// Self-checking bench for the waveform unit core and its shutdown and dead-band logic.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module wsd_core_tb_top;
	logic        mclk;
	logic        reset;
	logic [5:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        data_in;
	logic [6:0]  src;
	logic [3:0]  out_level;
	logic [3:0]  out_oe_n;
	logic [3:0]  pin_seen;
	logic        irq;
	logic [31:0] rd;
	int          fail_count = 0;
	int          cmp_count = 0;

	wsd_core DUT (
		.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
		.byteenable(4'hF), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .data_in(data_in), .shutdown_pin(src[0]),
		.timer_a_postscaled(src[1]), .timer_b_postscaled(src[2]),
		.timer_c_postscaled(src[3]), .comparator_a_output(src[4]),
		.comparator_b_output(src[5]), .logic_cell_output(src[6]),
		.out_level(out_level), .out_oe_n(out_oe_n), .irq(irq)
	);

	wsd_drv_model drv (.mclk(mclk), .out_level(out_level), .out_oe_n(out_oe_n),
		.pin_seen(pin_seen));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Holds the request until waitrequest is sampled low and releases it on that edge.
	// One more edge passes so the next request never meets this one's release.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
		address   <= a;
		writedata <= {24'h000000, d};
		write     <= wr;
		read      <= !wr;
		@(posedge mclk);
		while (waitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		rd = readdata;
		write <= 1'b0;
		read  <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] ex);
		bus(1'b0, a, 8'h00);
		`CHK(nm, ex, rd)
	endtask

	task automatic test_regs();
		rdchk("as1_reset", wsd_pkg::OFS_AS1, 32'h00000000);
		rdchk("as0_reset", wsd_pkg::OFS_AS0, 32'h00000014);
		wr(wsd_pkg::OFS_AS1, 8'hFF);
		rdchk("as1_top_bit", wsd_pkg::OFS_AS1, 32'h0000007F);
		wr(wsd_pkg::OFS_DBR, 8'hFF);
		rdchk("dbr_width", wsd_pkg::OFS_DBR, 32'h0000003F);
		wr(wsd_pkg::OFS_DBF, 8'hFF);
		rdchk("dbf_width", wsd_pkg::OFS_DBF, 32'h0000003F);
		rdchk("unmapped", 6'h3C, 32'h00000000);
		wr(wsd_pkg::OFS_CLK, 8'hFF);
		rdchk("clk_width", wsd_pkg::OFS_CLK, 32'h00000001);
		wr(wsd_pkg::OFS_ISM, 8'hFF);
		rdchk("ism_width", wsd_pkg::OFS_ISM, 32'h0000001F);
		wr(wsd_pkg::OFS_CON1, 8'hFF);
		rdchk("con1_width", wsd_pkg::OFS_CON1, 32'h0000000F);
		wr(wsd_pkg::OFS_CON1, 8'h00);
		wr(wsd_pkg::OFS_STR, 8'hA5);
		rdchk("str_value", wsd_pkg::OFS_STR, 32'h000000A5);
		`CHK("str_override", 4'hA, out_level)
		rdchk("istat_idle", wsd_pkg::OFS_ISTAT, 32'h00000000);
		wr(wsd_pkg::OFS_IMASK, 8'hFF);
		rdchk("imask_width", wsd_pkg::OFS_IMASK, 32'h00000003);
		wr(wsd_pkg::OFS_CON0, 8'hFF);
		rdchk("con0_width", wsd_pkg::OFS_CON0, 32'h00000087);
		wr(wsd_pkg::OFS_CON0, 8'h00);
		wr(wsd_pkg::OFS_AS1, 8'h00);
		$display("test regs done");
	endtask

	// Each source alone, first with only the others enabled, then with itself enabled.
	task automatic test_sources();
		logic [6:0] bit_i;
		wr(wsd_pkg::OFS_CON0, 8'h81);
		wr(wsd_pkg::OFS_STR, 8'h0F);
		wr(wsd_pkg::OFS_CON1, 8'h00);
		wr(wsd_pkg::OFS_IMASK, 8'h01);
		for (int i = 0; i < 7; i++) begin
			bit_i = 7'h01 << i;
			data_in <= 1'b0;
			wr(wsd_pkg::OFS_AS0, 8'h38);
			wr(wsd_pkg::OFS_AS1, {1'b0, ~bit_i});
			src <= bit_i;
			wait_cyc(8);
			rdchk("src_ignored", wsd_pkg::OFS_AS0, 32'h00000038);
			wr(wsd_pkg::OFS_AS1, {1'b0, bit_i});
			wait_cyc(8);
			rdchk("src_trips", wsd_pkg::OFS_AS0, 32'h000000B8);
			`CHK("sd_pins", 4'hA, out_level)
			`CHK("sd_irq", 1'b1, irq)
			src <= 7'h00;
			wait_cyc(4);
			wr(wsd_pkg::OFS_AS0, 8'h38);
			wait_cyc(10);
			`CHK("sd_hold", 4'hA, out_level)
			wr(wsd_pkg::OFS_ISTAT, 8'h01);
			`CHK("irq_clear", 1'b0, irq)
			data_in <= 1'b1;
			wait_cyc(8);
			`CHK("restart", 4'hF, out_level)
		end
		$display("test sources done");
	endtask

	// Every shutdown state code on both pairs, with polarity set on A and C.
	task automatic test_codes();
		logic [3:0] exp_tbl [4] = '{4'h5, 4'hA, 4'h0, 4'hF};
		logic [1:0] code;
		wr(wsd_pkg::OFS_CON0, 8'h80);
		wr(wsd_pkg::OFS_CON1, 8'h05);
		wr(wsd_pkg::OFS_AS1, 8'h01);
		data_in <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			code = k[1:0];
			wr(wsd_pkg::OFS_AS0, {2'h0, code, code, 2'h0});
			wait_cyc(4);
			`CHK("pre_pins", 4'h5, pin_seen)
			src <= 7'h01;
			wait_cyc(8);
			`CHK("ls_oe", (code == wsd_pkg::LS_TRI) ? 4'hF : 4'h0, out_oe_n)
			`CHK("ls_pins", exp_tbl[k], pin_seen)
			if (k == 2) begin
				wr(wsd_pkg::OFS_IMASK, 8'h00);
				`CHK("irq_masked", 1'b0, irq)
				wr(wsd_pkg::OFS_IMASK, 8'h01);
				`CHK("irq_unmasked", 1'b1, irq)
			end
			src <= 7'h00;
			wait_cyc(4);
			wr(wsd_pkg::OFS_AS0, {2'h0, code, code, 2'h0});
			wr(wsd_pkg::OFS_ISTAT, 8'h01);
			data_in <= 1'b1;
			wait_cyc(8);
			data_in <= 1'b0;
			wait_cyc(8);
		end
		$display("test codes done");
	endtask

	// Auto-restart: shutdown outlives its source until data rises, then clears by itself.
	task automatic test_restart();
		wr(wsd_pkg::OFS_IMASK, 8'h02);
		wr(wsd_pkg::OFS_AS0, 8'h6C);
		src <= 7'h01;
		wait_cyc(8);
		`CHK("ren_sd_pins", 4'h5, out_level)
		src <= 7'h00;
		wait_cyc(8);
		rdchk("ren_waits", wsd_pkg::OFS_AS0, 32'h000000EC);
		`CHK("ren_irq_masked", 1'b0, irq)
		data_in <= 1'b1;
		wait_cyc(8);
		rdchk("ren_cleared", wsd_pkg::OFS_AS0, 32'h0000006C);
		rdchk("ren_status", wsd_pkg::OFS_ISTAT, 32'h00000003);
		`CHK("ren_irq", 1'b1, irq)
		`CHK("ren_pins", 4'hA, out_level)
		wr(wsd_pkg::OFS_ISTAT, 8'h03);
		`CHK("ren_irq_clear", 1'b0, irq)
		data_in <= 1'b0;
		wr(wsd_pkg::OFS_IMASK, 8'h01);
		$display("test restart done");
	endtask

	task automatic rise_time(input int idx, input logic lvl, output int n);
		n = 0;
		data_in <= lvl;
		@(posedge mclk);
		while (out_level[idx] !== 1'b1 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		wait_cyc(80);
	endtask

	// Delays are measured against a zero count, so the fixed pipeline cancels out.
	task automatic test_deadband();
		int nt [3] = '{1, 2, 63};
		int br;
		int bf;
		int dr;
		int df;
		wr(wsd_pkg::OFS_CON1, 8'h00);
		wr(wsd_pkg::OFS_AS1, 8'h00);
		wr(wsd_pkg::OFS_CON0, 8'h84);
		wr(wsd_pkg::OFS_DBR, 8'h00);
		wr(wsd_pkg::OFS_DBF, 8'h00);
		wait_cyc(80);
		rise_time(0, 1'b1, br);
		rise_time(1, 1'b0, bf);
		for (int j = 0; j < 3; j++) begin
			wr(wsd_pkg::OFS_DBR, nt[j][7:0]);
			wr(wsd_pkg::OFS_DBF, nt[j][7:0]);
			rise_time(0, 1'b1, dr);
			rise_time(1, 1'b0, df);
			`CHK("rise_delay", 1'b1, (dr - br == nt[j]) || (dr - br == nt[j] + 1))
			`CHK("fall_delay", 1'b1, (df - bf == nt[j]) || (df - bf == nt[j] + 1))
		end
		$display("test deadband done");
	endtask

	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		reset     = 1'b1;
		address   = 6'h00;
		read      = 1'b0;
		write     = 1'b0;
		writedata = 32'h00000000;
		data_in   = 1'b0;
		src       = 7'h00;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		test_regs();
		test_sources();
		test_codes();
		test_restart();
		test_deadband();
		close_out();
	end

	// The whole run needs under two thousand cycles; this ceiling only cuts a hang short.
	initial begin
		repeat (20000) @(posedge mclk);
		`CHK("timeout", 1'b0, 1'b1)
		close_out();
	end
endmodule
`default_nettype wire

// ==== tb/wsd_drv_model.sv ====
// Behavioural model of the power stage that the unit's four output pins feed.
`timescale 1ns/100ps
`default_nettype none
module wsd_drv_model (
	// Clock
	input  wire logic       mclk,
	// Pins from the unit
	input  wire logic [3:0] out_level,
	input  wire logic [3:0] out_oe_n,
	// Levels the power stage actually sees
	output logic      [3:0] pin_seen
);
	logic [3:0] last_r;

	// Gate inputs have no keeper, so a released pin shows the inverse of its last level.
	// This keeps the simulator from quietly settling a floating pin to a lucky value.
	assign pin_seen = (out_level & ~out_oe_n) | (~last_r & out_oe_n);

	always_ff @(posedge mclk) begin
		last_r <= (out_level & ~out_oe_n) | (last_r & out_oe_n);
	end
endmodule
`default_nettype wire

// ==== verilog/wsd_core.sv ====
// Complementary waveform unit core: register slave, auto-shutdown and output stage.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module wsd_core (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// Register bus
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Waveform data and shutdown sources
	input  wire logic        data_in,
	input  wire logic        shutdown_pin,
	input  wire logic        timer_a_postscaled,
	input  wire logic        timer_b_postscaled,
	input  wire logic        timer_c_postscaled,
	input  wire logic        comparator_a_output,
	input  wire logic        comparator_b_output,
	input  wire logic        logic_cell_output,
	// Output pins A to D and interrupt
	output logic      [3:0]  out_level,
	output logic      [3:0]  out_oe_n,
	output logic             irq
);
	localparam int SYN_W = wsd_pkg::SRC_N + 1;

	// Returns {oe_n, level} for a pin in shutdown.
	function automatic logic [1:0] sd_pin(input logic [1:0] state, input logic inact);
		case (state)
			wsd_pkg::LS_HIGH:  sd_pin = 2'h1;
			wsd_pkg::LS_LOW:   sd_pin = 2'h0;
			wsd_pkg::LS_TRI:   sd_pin = 2'h2;
			default:           sd_pin = {1'b0, inact};
		endcase
	endfunction

	function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Synchroniser: the first stage feeds only the second.
	logic [SYN_W-1:0] sync1_r;
	logic [SYN_W-1:0] sync2_r;
	wire  [SYN_W-1:0] raw_in;
	logic             data_d_r;

	// Register state.
	logic             wait_r;
	logic [31:0]      readdata_r;
	logic             en_r;
	logic [2:0]       mode_r;
	logic [3:0]       pol_r;
	logic             clk_sel_r;
	logic [4:0]       ism_r;
	logic [7:0]       str_r;
	logic             shutdown_r;
	logic             ren_r;
	logic [1:0]       ls_bd_r;
	logic [1:0]       ls_ac_r;
	logic [wsd_pkg::SRC_N-1:0] as1_r;
	logic [wsd_pkg::DB_W-1:0]  dbr_r;
	logic [wsd_pkg::DB_W-1:0]  dbf_r;
	logic [wsd_pkg::IRQ_W-1:0] istat_r;
	logic [wsd_pkg::IRQ_W-1:0] imask_r;
	logic             hold_r;
	logic [3:0]       out_r;
	logic [3:0]       oen_r;
	logic             irq_r;

	assign raw_in = {data_in, logic_cell_output, comparator_b_output, comparator_a_output,
		timer_c_postscaled, timer_b_postscaled, timer_a_postscaled, shutdown_pin};

	wire       data_s   = sync2_r[wsd_pkg::SRC_N];
	wire [wsd_pkg::SRC_N-1:0] src_s = sync2_r[wsd_pkg::SRC_N-1:0];
	wire       data_rise = data_s & ~data_d_r;

	// Bus decode: a request waits one cycle, then is taken on the edge with waitrequest low.
	wire       req     = read | write;
	wire       wait_nxt = ~(req & wait_r);
	wire       wr_en   = write & ~wait_r & byteenable[0];
	wire [7:0] wd      = writedata[7:0];
	wire       wr_con0 = wr_en & hit(address, wsd_pkg::OFS_CON0);
	wire       wr_con1 = wr_en & hit(address, wsd_pkg::OFS_CON1);
	wire       wr_clk  = wr_en & hit(address, wsd_pkg::OFS_CLK);
	wire       wr_ism  = wr_en & hit(address, wsd_pkg::OFS_ISM);
	wire       wr_str  = wr_en & hit(address, wsd_pkg::OFS_STR);
	wire       wr_as0  = wr_en & hit(address, wsd_pkg::OFS_AS0);
	wire       wr_as1  = wr_en & hit(address, wsd_pkg::OFS_AS1);
	wire       wr_dbr  = wr_en & hit(address, wsd_pkg::OFS_DBR);
	wire       wr_dbf  = wr_en & hit(address, wsd_pkg::OFS_DBF);
	wire       wr_ist  = wr_en & hit(address, wsd_pkg::OFS_ISTAT);
	wire       wr_imk  = wr_en & hit(address, wsd_pkg::OFS_IMASK);

	wire [7:0] rd_mux =
		hit(address, wsd_pkg::OFS_CON0) ? {en_r, 4'h0, mode_r} :
		hit(address, wsd_pkg::OFS_CON1) ? {2'h0, data_s, 1'b0, pol_r} :
		hit(address, wsd_pkg::OFS_CLK)  ? {7'h00, clk_sel_r} :
		hit(address, wsd_pkg::OFS_ISM)  ? {3'h0, ism_r} :
		hit(address, wsd_pkg::OFS_STR)  ? str_r :
		hit(address, wsd_pkg::OFS_AS0)  ? {shutdown_r, ren_r, ls_bd_r, ls_ac_r, 2'h0} :
		hit(address, wsd_pkg::OFS_AS1)  ? {1'b0, as1_r} :
		hit(address, wsd_pkg::OFS_DBR)  ? {2'h0, dbr_r} :
		hit(address, wsd_pkg::OFS_DBF)  ? {2'h0, dbf_r} :
		hit(address, wsd_pkg::OFS_ISTAT) ? {6'h00, istat_r} :
		hit(address, wsd_pkg::OFS_IMASK) ? {6'h00, imask_r} : wsd_pkg::BYTE_ZERO;
	wire [31:0] rd_nxt = (read & wait_r) ? {wsd_pkg::PAD_ZERO, rd_mux} : readdata_r;

	// Each enabled source sets shutdown; the hardware set beats a software clear.
	wire [wsd_pkg::SRC_N-1:0] src_hit = src_s & as1_r;
	wire       src_active = |src_hit;
	wire       restart    = ren_r & shutdown_r & ~src_active & data_rise;
	wire       sd_nxt     = src_active ? 1'b1 :
		wr_as0 ? wd[wsd_pkg::AS0_SD] :
		restart ? 1'b0 : shutdown_r;
	// Outputs leave the shutdown state only on a data rising edge.
	wire       hold_nxt   = sd_nxt | (hold_r & ~data_rise);

	wire [wsd_pkg::IRQ_W-1:0] ev;
	assign ev[wsd_pkg::IRQ_SD]      = sd_nxt & ~shutdown_r;
	assign ev[wsd_pkg::IRQ_RESTART] = restart;
	wire [wsd_pkg::IRQ_W-1:0] w1c = wr_ist ? wd[wsd_pkg::IRQ_W-1:0] : 2'h0;
	wire [wsd_pkg::IRQ_W-1:0] istat_nxt = (istat_r & ~w1c) | ev;
	wire [wsd_pkg::IRQ_W-1:0] imask_nxt = wr_imk ? wd[wsd_pkg::IRQ_W-1:0] : imask_r;
	wire       irq_nxt = |(istat_nxt & imask_nxt);

	// Dead-band paths: both inputs drop in shutdown so a pin on the inactive-state code sits at its inactive level.
	wsd_dband_if rise_if ();
	wsd_dband_if fall_if ();
	assign rise_if.in_level = data_s & en_r & ~hold_r;
	assign rise_if.count    = dbr_r;
	assign fall_if.in_level = ~data_s & en_r & ~hold_r;
	assign fall_if.count    = dbf_r;

	wsd_dband u_rise (
		.mclk  (mclk),
		.reset (reset),
		.link  (rise_if)
	);
	wsd_dband u_fall (
		.mclk  (mclk),
		.reset (reset),
		.link  (fall_if)
	);

	// Only the steering and half-bridge modes are built; other codes run as half-bridge.
	wire steer = (mode_r == wsd_pkg::MODE_STEER) | (mode_r == wsd_pkg::MODE_STEER_SYNC);
	wire [3:0] lvl_nxt;
	wire [3:0] oen_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			localparam bit PAIR_BD = (gi % 2) == 1;
			wire       path   = PAIR_BD ? fall_if.out_level : rise_if.out_level;
			wire [1:0] state  = PAIR_BD ? ls_bd_r : ls_ac_r;
			wire       inact  = path ^ pol_r[gi];
			wire       run_lv = steer ? (str_r[gi] ? ((data_s & en_r) ^ pol_r[gi])
				: str_r[wsd_pkg::STR_OVR_LO + gi]) : inact;
			wire [1:0] sd     = sd_pin(state, inact);
			assign lvl_nxt[gi] = hold_r ? sd[0] : run_lv;
			assign oen_nxt[gi] = hold_r & sd[1];
		end
	endgenerate

	always_ff @(posedge mclk) begin
		sync1_r <= raw_in;
		sync2_r <= sync1_r;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wait_r     <= 1'b1;
			readdata_r <= 32'h00000000;
			data_d_r   <= 1'b0;
			shutdown_r <= 1'b0;
			hold_r     <= 1'b0;
			out_r      <= 4'h0;
			oen_r      <= 4'h0;
			istat_r    <= 2'h0;
			imask_r    <= 2'h0;
			irq_r      <= 1'b0;
		end else begin
			wait_r     <= wait_nxt;
			readdata_r <= rd_nxt;
			data_d_r   <= data_s;
			shutdown_r <= sd_nxt;
			hold_r     <= hold_nxt;
			out_r      <= lvl_nxt;
			oen_r      <= oen_nxt;
			istat_r    <= istat_nxt;
			imask_r    <= imask_nxt;
			irq_r      <= irq_nxt;
		end
	end

	// Configuration registers; bit 7 of the source enables has no storage.
	always_ff @(posedge mclk) begin
		if (reset) begin
			en_r      <= 1'b0;
			mode_r    <= 3'h0;
			pol_r     <= 4'h0;
			clk_sel_r <= 1'b0;
			ism_r     <= 5'h00;
			str_r     <= 8'h00;
			ren_r     <= 1'b0;
			ls_bd_r   <= wsd_pkg::LS_RST;
			ls_ac_r   <= wsd_pkg::LS_RST;
			as1_r     <= 7'h00;
			dbr_r     <= 6'h00;
			dbf_r     <= 6'h00;
		end else begin
			if (wr_con0) begin
				en_r   <= wd[wsd_pkg::CON0_EN];
				mode_r <= wd[2:0];
			end
			if (wr_con1) begin
				pol_r <= wd[3:0];
			end
			if (wr_clk) begin
				clk_sel_r <= wd[0];
			end
			if (wr_ism) begin
				ism_r <= wd[4:0];
			end
			if (wr_str) begin
				str_r <= wd;
			end
			if (wr_as0) begin
				ren_r   <= wd[wsd_pkg::AS0_REN];
				ls_bd_r <= wd[wsd_pkg::AS0_BD_LO +: 2];
				ls_ac_r <= wd[wsd_pkg::AS0_AC_LO +: 2];
			end
			if (wr_as1) begin
				as1_r <= wd[wsd_pkg::SRC_N-1:0];
			end
			if (wr_dbr) begin
				dbr_r <= wd[wsd_pkg::DB_W-1:0];
			end
			if (wr_dbf) begin
				dbf_r <= wd[wsd_pkg::DB_W-1:0];
			end
		end
	end

	assign readdata    = readdata_r;
	assign waitrequest = wait_r;
	assign out_level   = out_r;
	assign out_oe_n    = oen_r;
	assign irq         = irq_r;

	sequence s_pin_hit;
		sync2_r[wsd_pkg::SRC_PIN] && as1_r[wsd_pkg::SRC_PIN];
	endsequence

	property p_as1_top;
		@(posedge mclk) disable iff (reset)
		read && wait_r && hit(address, wsd_pkg::OFS_AS1) |=> !readdata_r[7] && !wait_r;
	endproperty
	a_as1_top: assert property (p_as1_top) else $error("source enable top bit not zero");

	property p_cell_sd;
		@(posedge mclk) disable iff (reset)
		sync2_r[wsd_pkg::SRC_CELL] && as1_r[wsd_pkg::SRC_CELL] |=> shutdown_r;
	endproperty
	a_cell_sd: assert property (p_cell_sd) else $error("logic cell did not shut down");

	property p_cmpb_sd;
		@(posedge mclk) disable iff (reset)
		sync2_r[wsd_pkg::SRC_CMP_B] && as1_r[wsd_pkg::SRC_CMP_B] |=> shutdown_r;
	endproperty
	a_cmpb_sd: assert property (p_cmpb_sd) else $error("comparator B did not shut down");

	property p_cmpa_sd;
		@(posedge mclk) disable iff (reset)
		sync2_r[wsd_pkg::SRC_CMP_A] && as1_r[wsd_pkg::SRC_CMP_A] |=> shutdown_r;
	endproperty
	a_cmpa_sd: assert property (p_cmpa_sd) else $error("comparator A did not shut down");

	property p_tmr_sd;
		@(posedge mclk) disable iff (reset)
		|(sync2_r[wsd_pkg::SRC_TMR_C:wsd_pkg::SRC_TMR_A] & as1_r[3:1]) |=> shutdown_r;
	endproperty
	a_tmr_sd: assert property (p_tmr_sd) else $error("timer did not shut down");

	property p_pin_sd;
		@(posedge mclk) disable iff (reset)
		s_pin_hit |=> shutdown_r ##1 hold_r;
	endproperty
	a_pin_sd: assert property (p_pin_sd) else $error("pin did not shut down");

	property p_no_spurious;
		@(posedge mclk) disable iff (reset)
		!shutdown_r && !src_active && !wr_as0 |=> !shutdown_r;
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("shutdown without source");

	property p_hold_edge;
		@(posedge mclk) disable iff (reset)
		hold_r && !shutdown_r && !data_rise |=> hold_r;
	endproperty
	a_hold_edge: assert property (p_hold_edge) else $error("outputs left shutdown early");

	property p_ls_high;
		@(posedge mclk) disable iff (reset)
		hold_r && (ls_ac_r == wsd_pkg::LS_HIGH) |=> out_r[0] && !oen_r[0] && out_r[2];
	endproperty
	a_ls_high: assert property (p_ls_high) else $error("pair A/C not driven high");

	property p_ls_tri;
		@(posedge mclk) disable iff (reset)
		hold_r && (ls_bd_r == wsd_pkg::LS_TRI) |=> oen_r[1] && oen_r[3];
	endproperty
	a_ls_tri: assert property (p_ls_tri) else $error("pair B/D not released");
endmodule
`default_nettype wire

// ==== verilog/wsd_dband.sv ====
// Dead-band stage: delays the rising edge of its input by the programmed count.
`timescale 1ns/100ps
`default_nettype none
module wsd_dband (
	// Clock and reset
	input  wire logic   mclk,
	input  wire logic   reset,
	// Stage link
	wsd_dband_if.delay  link
);
	logic [wsd_pkg::DB_W-1:0] cnt_r;
	logic [wsd_pkg::DB_W-1:0] cnt_nxt;
	logic                     out_r;
	logic                     out_nxt;
	wire                      reached;

	// Counting on >= keeps the stage sane if software lowers the count mid-delay.
	assign reached = (cnt_r >= link.count);
	assign out_nxt = link.in_level & (out_r | reached);
	assign cnt_nxt = (link.in_level & ~out_r) ? cnt_r + 6'h01 : 6'h00;
	assign link.out_level = out_r;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_r <= 6'h00;
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end

	property p_dband_wait;
		@(posedge mclk) disable iff (reset)
		link.in_level && !out_r && (cnt_r < link.count) |=> !out_r;
	endproperty
	a_dband_wait: assert property (p_dband_wait) else $error("dead-band ended early");

	property p_dband_fire;
		@(posedge mclk) disable iff (reset)
		link.in_level && !out_r && (cnt_r >= link.count) |=> out_r;
	endproperty
	a_dband_fire: assert property (p_dband_fire) else $error("dead-band ended late");
endmodule
`default_nettype wire

// ==== verilog/wsd_dband_if.sv ====
// Interface joining the core to one dead-band delay stage.
`timescale 1ns/100ps
`default_nettype none
interface wsd_dband_if;
	logic                   in_level;
	logic [wsd_pkg::DB_W-1:0] count;
	logic                   out_level;
	modport host  (output in_level, output count, input out_level);
	modport delay (input in_level, input count, output out_level);
endinterface
`default_nettype wire

// ==== verilog/wsd_pkg.sv ====
// Package with register map, field positions and reset values of the waveform unit.
package wsd_pkg;
	localparam int          DATA_W = 32;
	localparam int          ADDR_W = 6;
	localparam int          DB_W   = 6;
	localparam int          SRC_N  = 7;
	localparam int          IRQ_W  = 2;

	// Byte offsets on the register bus.
	localparam logic [5:0]  OFS_CON0   = 6'h00;
	localparam logic [5:0]  OFS_CON1   = 6'h04;
	localparam logic [5:0]  OFS_CLK    = 6'h08;
	localparam logic [5:0]  OFS_ISM    = 6'h0C;
	localparam logic [5:0]  OFS_STR    = 6'h10;
	localparam logic [5:0]  OFS_AS0    = 6'h14;
	localparam logic [5:0]  OFS_AS1    = 6'h18;
	localparam logic [5:0]  OFS_DBR    = 6'h1C;
	localparam logic [5:0]  OFS_DBF    = 6'h20;
	localparam logic [5:0]  OFS_ISTAT  = 6'h24;
	localparam logic [5:0]  OFS_IMASK  = 6'h28;

	// Field positions.
	localparam int          CON0_EN    = 7;
	localparam int          CON1_IN    = 5;
	localparam int          AS0_SD     = 7;
	localparam int          AS0_REN    = 6;
	localparam int          AS0_BD_LO  = 4;
	localparam int          AS0_AC_LO  = 2;
	localparam int          STR_OVR_LO = 4;
	localparam int          SRC_PIN    = 0;
	localparam int          SRC_TMR_A  = 1;
	localparam int          SRC_TMR_B  = 2;
	localparam int          SRC_TMR_C  = 3;
	localparam int          SRC_CMP_A  = 4;
	localparam int          SRC_CMP_B  = 5;
	localparam int          SRC_CELL   = 6;
	localparam int          IRQ_SD     = 0;
	localparam int          IRQ_RESTART = 1;

	// Reset value of the shutdown-state fields and zero fills for read data.
	localparam logic [1:0]  LS_RST     = 2'h1;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [23:0] PAD_ZERO   = 24'h000000;

	// Shutdown output-state codes.
	localparam logic [1:0]  LS_HIGH    = 2'h3;
	localparam logic [1:0]  LS_LOW     = 2'h2;
	localparam logic [1:0]  LS_TRI     = 2'h1;
	localparam logic [1:0]  LS_INACT   = 2'h0;

	// Operating modes.
	localparam logic [2:0]  MODE_STEER      = 3'h0;
	localparam logic [2:0]  MODE_STEER_SYNC = 3'h1;
	localparam logic [2:0]  MODE_HALF       = 3'h4;
endpackage
